// >>> core/rsv_defs.svh
//==============================================================
`ifndef RSV_DEFS_SVH
`define RSV_DEFS_SVH
// register addresses, bit 3 selects the second channel for the vector register only (4'ha against 4'h2), 4'h8 is interrupt enable
`define RSV_A_DATA 4'h0
`define RSV_A_STAT 4'h1
`define RSV_A_VEC_A 4'h2
`define RSV_A_CMD 4'h3
`define RSV_A_CTRL 4'h4
`define RSV_A_VWR 4'h5
`define RSV_A_IST 4'h6
`define RSV_A_ICLR 4'h7
`define RSV_A_IEN 4'h8
`define RSV_A_VEC_B 4'ha
// command field and code
`define RSV_CMD_MSB 5
`define RSV_CMD_LSB 3
`define RSV_CMD_ERR_RST 3'h6
// control fields
`define RSV_C_SAV 0
`define RSV_C_PEN 1
`define RSV_C_PODD 2
`define RSV_C_MODE_MSB 4
`define RSV_C_MODE_LSB 3
`define RSV_C_LEN_MSB 6
`define RSV_C_LEN_LSB 5
`define RSV_CTRL_RST 8'h60
`define RSV_VEC_RST 8'h00
// vector codes for bits 3..1
`define RSV_VC_SPEC 3'h7
`define RSV_VC_AVAIL 3'h6
`define RSV_VC_NONE 3'h3
// status and vector bit positions
`define RSV_S_SENT 0
`define RSV_S_RES_LSB 1
`define RSV_S_RES_MSB 3
`define RSV_S_PAR 4
`define RSV_S_OVR 5
`define RSV_S_CRC 6
`define RSV_S_EOF 7
`define RSV_V_LSB 1
`define RSV_V_MSB 3
// fifo and timing
`define RSV_DEPTH 2'h3
`define RSV_CLK_NS 100
`define RSV_BIT_NS 104167
`define RSV_HALF_CYC \
  ((`RSV_BIT_NS + 2 * `RSV_CLK_NS - 1) / (2 * `RSV_CLK_NS))
`define RSV_RES_OFS 3'h4
`endif

// >>> core/rsv_pkg.sv
//==============================================================
// types of the receive status block
package rsv_pkg;
  typedef enum logic [1:0]
  {
    RSV_ASYNC = 2'b00,
    RSV_SYNC = 2'b01,
    RSV_SDLC = 2'b10
  } rsv_mode_t;
  // one received character with its status
  typedef struct packed {
    logic [7:0] data;
    logic par;
    logic crc;
    logic ovr;
    logic eof;
    logic [2:0] res;
  } rsv_ent_t;
  // all state of the block
  typedef struct packed {
    rsv_ent_t [2:0] fifo;
    logic [1:0] cnt;
    logic par_l;
    logic ovr_l;
    logic [7:0] ctrl;
    logic [7:0] vec;
    logic [1:0] ist;
    logic [1:0] ien;
    logic [7:0] rdata;
    logic [9:0] hold;
  } rsv_state_t;
endpackage : rsv_pkg

// >>> core/rsv_top.sv
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`include "rsv_defs.svh"
module rsv_top
  import rsv_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [7:0] rx_char_i,
  input wire logic rx_par_i,
  input wire logic rx_valid_i,
  input wire logic frame_err_i,
  input wire logic crc_err_i,
  input wire logic close_flag_i,
  input wire logic [2:0] resid_bits_i,
  input wire logic all_sent_i,
  output logic rx_hold_o,
  output logic irq_o
);

  //==============================================================
  // state and decode
  rsv_state_t s_r;
  rsv_state_t s_nxt;
  rsv_mode_t mode;
  logic [1:0] len;
  logic [7:0] mask;
  logic push;
  logic pop;
  logic er;
  logic par_bad;
  logic [2:0] n;
  logic [2:0] code;
  logic [1:0] pend;
  logic [1:0] ist_set;
  logic [7:0] stat;
  logic [7:0] vec_rd;
  logic [3:0] shamt;
  rsv_ent_t ent;

  // control fields and strobes
  assign mode = rsv_mode_t'(s_r.ctrl[`RSV_C_MODE_MSB:`RSV_C_MODE_LSB]);
  assign len = s_r.ctrl[`RSV_C_LEN_MSB:`RSV_C_LEN_LSB];
  assign push = rx_valid_i | close_flag_i;
  assign pop = rd_i & (addr_i == `RSV_A_DATA) & (s_r.cnt != 2'h0);
  assign er = wr_i & (addr_i == `RSV_A_CMD)
    & (wdata_i[`RSV_CMD_MSB:`RSV_CMD_LSB] == `RSV_CMD_ERR_RST);

  //==============================================================
  // incoming character classification
  always_comb
  begin
    case (len)
      2'h0: mask = 8'h1f;
      2'h1: mask = 8'h3f;
      2'h2: mask = 8'h7f;
      default: mask = 8'hff;
    endcase
  end

  // parity against programmed sense
  assign par_bad = (^(rx_char_i & mask)) ^ rx_par_i
    ^ s_r.ctrl[`RSV_C_PODD];

  // residue counter offset by length, bits read reversed
  assign n = resid_bits_i + `RSV_RES_OFS - {len[1:0], 1'b0};
  assign code = {n[0], n[1], n[2]};
  assign shamt = 4'h8 - {1'b0, resid_bits_i};

  // build the entry for a new character
  always_comb
  begin
    ent = '0;
    ent.data = rx_char_i;
    if (close_flag_i && (resid_bits_i != 3'h0))
    begin
      ent.data = rx_char_i >> shamt;
    end
    ent.par = s_r.ctrl[`RSV_C_PEN] & par_bad & rx_valid_i;
    if (mode == RSV_ASYNC)
    begin
      ent.crc = frame_err_i;
    end
    else
    begin
      ent.crc = crc_err_i;
    end
    ent.eof = close_flag_i & (mode == RSV_SDLC);
    if (ent.eof)
    begin
      ent.res = code;
    end
  end

  //==============================================================
  // next state
  always_comb
  begin
    s_nxt = s_r;
    ist_set = 2'h0;
    // error reset clears latches and the head crc and end of frame flags, not the head overrun tag
    if (er)
    begin
      s_nxt.par_l = 1'b0;
      s_nxt.ovr_l = 1'b0;
      s_nxt.fifo[0].crc = 1'b0;
      s_nxt.fifo[0].eof = 1'b0;
    end
    // reading a character pops it, overrun tag latches
    if (pop)
    begin
      if (s_r.fifo[0].ovr)
      begin
        s_nxt.ovr_l = 1'b1;
      end
      s_nxt.fifo[0] = s_nxt.fifo[1];
      s_nxt.fifo[1] = s_nxt.fifo[2];
      s_nxt.fifo[2] = '0;
      s_nxt.cnt = s_r.cnt - 2'h1;
    end
    // new character, overwrite the last one when full
    if (push)
    begin
      if (s_nxt.cnt == `RSV_DEPTH)
      begin
        s_nxt.fifo[2] = ent;
        s_nxt.fifo[2].ovr = 1'b1;
        ist_set[0] = 1'b1;
      end
      else
      begin
        s_nxt.fifo[s_nxt.cnt] = ent;
        s_nxt.cnt = s_nxt.cnt + 2'h1;
      end
      if (ent.par)
      begin
        s_nxt.par_l = 1'b1;
      end
      if (ent.par | ent.crc | ent.eof)
      begin
        ist_set[0] = 1'b1;
      end
      ist_set[1] = 1'b1;
      if ((mode == RSV_ASYNC) && frame_err_i)
      begin
        s_nxt.hold = 10'(`RSV_HALF_CYC);
      end
    end
    // half bit extension countdown
    if ((s_r.hold != 10'h0) && (s_nxt.hold == s_r.hold))
    begin
      s_nxt.hold = s_r.hold - 10'h1;
    end
    // register writes
    if (wr_i)
    begin
      case (addr_i)
        `RSV_A_CTRL: s_nxt.ctrl = wdata_i;
        `RSV_A_VWR: s_nxt.vec = wdata_i;
        `RSV_A_IEN: s_nxt.ien = wdata_i[1:0];
        `RSV_A_ICLR: s_nxt.ist = s_r.ist & ~wdata_i[1:0];
        default: s_nxt.ctrl = s_nxt.ctrl;
      endcase
    end
    // events of this cycle win over a clear
    s_nxt.ist = s_nxt.ist | ist_set;
    // register reads, data valid the cycle after the strobe
    s_nxt.rdata = 8'h00;
    if (rd_i)
    begin
      case (addr_i)
        `RSV_A_DATA: s_nxt.rdata = (s_r.cnt != 2'h0) ?
          s_r.fifo[0].data : 8'h00;
        `RSV_A_STAT: s_nxt.rdata = stat;
        `RSV_A_VEC_B: s_nxt.rdata = vec_rd;
        `RSV_A_CTRL: s_nxt.rdata = s_r.ctrl;
        `RSV_A_IST: s_nxt.rdata = {6'h00, s_r.ist};
        `RSV_A_IEN: s_nxt.rdata = {6'h00, s_r.ien};
        default: s_nxt.rdata = 8'h00;
      endcase
    end
  end

  //==============================================================
  // status byte of the head character
  always_comb
  begin
    stat = 8'h00;
    stat[`RSV_S_SENT] = all_sent_i;
    stat[`RSV_S_PAR] = s_r.par_l;
    stat[`RSV_S_OVR] = s_r.ovr_l
      | ((s_r.cnt != 2'h0) & s_r.fifo[0].ovr);
    if (s_r.cnt != 2'h0)
    begin
      stat[`RSV_S_CRC] = s_r.fifo[0].crc;
      stat[`RSV_S_EOF] = s_r.fifo[0].eof;
      if (s_r.fifo[0].eof)
      begin
        stat[`RSV_S_RES_MSB:`RSV_S_RES_LSB] = s_r.fifo[0].res;
      end
    end
  end

  //==============================================================
  // vector readback with status modification
  assign pend = s_r.ist & s_r.ien;
  always_comb
  begin
    vec_rd = s_r.vec;
    if (s_r.ctrl[`RSV_C_SAV])
    begin
      if (pend[0])
      begin
        vec_rd[`RSV_V_MSB:`RSV_V_LSB] = `RSV_VC_SPEC;
      end
      else if (pend[1])
      begin
        vec_rd[`RSV_V_MSB:`RSV_V_LSB] = `RSV_VC_AVAIL;
      end
      else
      begin
        vec_rd[`RSV_V_MSB:`RSV_V_LSB] = `RSV_VC_NONE;
      end
    end
  end

  //==============================================================
  // state register
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s_r <= '0;
      s_r.ctrl <= `RSV_CTRL_RST;
      s_r.vec <= `RSV_VEC_RST;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // outputs
  assign rdata_o = s_r.rdata;
  assign rx_hold_o = (s_r.hold != 10'h0);
  assign irq_o = |pend;

  //==============================================================
  // checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);

  // parity error latches and stays until error reset
  par_latch_a:
  assert property (push && ent.par && !er |=> s_r.par_l [*2]
    or (s_r.par_l ##1 $past(er, 1)))
    else $error("parity flag not latched");

  // overrun tags the character that overwrites the last one
  ovr_tag_a:
  assert property (push && !pop && s_r.cnt == `RSV_DEPTH
    |=> s_r.fifo[2].ovr && s_r.ist[0])
    else $error("overrun not attached to last character");

  // reading a tagged character latches overrun
  ovr_hold_a:
  assert property (pop && s_r.fifo[0].ovr |=> s_r.ovr_l)
    else $error("overrun not held after read");

  // closing flag into empty buffer sets end of frame
  eof_set_a:
  assert property (close_flag_i && mode == RSV_SDLC
    && s_r.cnt == 2'h0 && !er |=> s_r.fifo[0].eof)
    else $error("end of frame not set");

  // error reset clears end of frame on a held head
  eof_clr_a:
  assert property (er && !pop && s_r.cnt != 2'h0
    |=> !s_r.fifo[0].eof && !s_r.fifo[0].crc)
    else $error("error reset left head flags");

  // framing error stretches the character
  half_bit_a:
  assert property (push && mode == RSV_ASYNC && frame_err_i
    |=> rx_hold_o [*8])
    else $error("framing hold too short");

  // residue reads zero without end of frame
  res_mask_a:
  assert property (rd_i && addr_i == `RSV_A_STAT
    && !(s_r.cnt != 2'h0 && s_r.fifo[0].eof)
    |=> rdata_o[3:1] == 3'h0)
    else $error("residue shown outside end of frame");

  // nothing pending gives the idle code
  vec_none_a:
  assert property (rd_i && addr_i == `RSV_A_VEC_B
    && s_r.ctrl[`RSV_C_SAV] && pend == 2'h0
    |=> rdata_o[3:1] == `RSV_VC_NONE)
    else $error("idle vector code wrong");

  // plain vector returned without status vectoring
  vec_raw_a:
  assert property (rd_i && addr_i == `RSV_A_VEC_B
    && !s_r.ctrl[`RSV_C_SAV] |=> rdata_o == $past(s_r.vec))
    else $error("written vector not returned");

  // vector not visible at the first channel
  vec_chan_a:
  assert property (rd_i && addr_i == `RSV_A_VEC_A |=> rdata_o == 8'h00)
    else $error("vector visible at first channel");

  // special condition outranks character available
  vec_prio_a:
  assert property (rd_i && addr_i == `RSV_A_VEC_B
    && s_r.ctrl[`RSV_C_SAV] && pend[0]
    |=> rdata_o[3:1] == `RSV_VC_SPEC)
    else $error("priority code wrong");

  // overrun with special interrupts enabled raises the line
  ovr_irq_a:
  assert property (push && !pop && s_r.cnt == `RSV_DEPTH && s_r.ien[0]
    && !wr_i |=> irq_o)
    else $error("overrun raised no interrupt");

  // crc/framing flag taken fresh from each character
  crc_new_a:
  assert property (push && s_r.cnt == 2'h0 && !er
    |=> s_r.fifo[0].crc == $past(mode == RSV_ASYNC ? frame_err_i
    : crc_err_i))
    else $error("crc flag not refreshed");

  // boundary residue code follows the character length
  res_edge_a:
  assert property (close_flag_i && mode == RSV_SDLC && s_r.cnt == 2'h0
    && resid_bits_i == 3'h0
    |=> s_r.fifo[0].res == $past(len == 2'h3 ? 3'b011 : len == 2'h2
    ? 3'b000 : len == 2'h1 ? 3'b010 : 3'b001))
    else $error("boundary residue code wrong");

  // a single residual bit lands in bit 0 of the data byte
  res_just_a:
  assert property (close_flag_i && s_r.cnt == 2'h0
    && resid_bits_i == 3'h1
    |=> s_r.fifo[0].data == {7'h00, $past(rx_char_i[7])})
    else $error("residual bits not right justified");

endmodule : rsv_top

// >>> tb/rsv_host.sv
`timescale 1ns/1ns
// host processor on the register port
module rsv_host
(
  input wire logic clock_i,
  input wire logic [7:0] rdata_i,
  output logic [3:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  // idle bus from time zero
  initial
  begin
    addr_o = 4'h0;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // one-cycle write, data scrambled once released
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clock_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask : wr
  // one-cycle read, data taken in the cycle after
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clock_i);
    rd_o <= 1'b0;
    #1;
    d = rdata_i;
  endtask : rd
endmodule : rsv_host

// >>> tb/tb_top.sv
`timescale 1ns/1ns
`include "rsv_defs.svh"
module tb_top;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [2:0] res;
    logic crc;
    logic [2:0] code;
  } rsv_row_t;
  //==============================================================
  // signals and instances
  logic clock_i = 1'b0;
  logic nrst_i;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic [7:0] rx_char;
  logic rx_par;
  logic rx_valid;
  logic ferr;
  logic cerr;
  logic close_f;
  logic [2:0] resid;
  logic all_sent;
  logic hold;
  logic irq;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [15:0] n;
  // sdlc rows: control, residual bits, crc error, residue code
  rsv_row_t rows [11] = '{
    '{8'h70, 3'd0, 1'b0, 3'b011}, '{8'h70, 3'd1, 1'b1, 3'b111},
    '{8'h70, 3'd2, 1'b0, 3'b000}, '{8'h70, 3'd3, 1'b1, 3'b100},
    '{8'h70, 3'd4, 1'b0, 3'b010}, '{8'h70, 3'd5, 1'b1, 3'b110},
    '{8'h70, 3'd6, 1'b0, 3'b001}, '{8'h70, 3'd7, 1'b1, 3'b101},
    '{8'h50, 3'd0, 1'b0, 3'b000}, '{8'h30, 3'd0, 1'b0, 3'b010},
    '{8'h10, 3'd0, 1'b1, 3'b001}};
  rsv_host i_rsv_host (.clock_i(clock_i), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  rsv_top i_rsv_top (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .rx_char_i(rx_char), .rx_par_i(rx_par), .rx_valid_i(rx_valid),
    .frame_err_i(ferr), .crc_err_i(cerr), .close_flag_i(close_f),
    .resid_bits_i(resid), .all_sent_i(all_sent), .rx_hold_o(hold),
    .irq_o(irq));
  // 100 ns clock and a hang limit
  always #50 clock_i = ~clock_i;
  always @(posedge clock_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_fail++;
      report_and_stop();
    end
  end
  //==============================================================
  // tasks
  task chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task rc(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_rsv_host.rd(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask : rc
  task push(input logic [7:0] c, input logic p, input logic fe,
    input logic ce, input logic cf, input logic [2:0] r);
    @(posedge clock_i);
    rx_char <= c;
    rx_par <= p;
    ferr <= fe;
    cerr <= ce;
    rx_valid <= ~cf;
    close_f <= cf;
    resid <= r;
    @(posedge clock_i);
    rx_valid <= 1'b0;
    close_f <= 1'b0;
  endtask : push
  task report_and_stop;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // main sequence
  initial
  begin
    {nrst_i, rx_char, rx_par, rx_valid, ferr, cerr} = '0;
    {close_f, resid, all_sent} = '0;
    repeat (10) @(posedge clock_i);
    nrst_i <= 1'b1;
    rc(`RSV_A_CTRL, 8'h60);
    rc(`RSV_A_VEC_B, 8'h00);
    rc(4'h9, 8'h00);
    rc(`RSV_A_VEC_A, 8'h00);
    chk({15'h0000, hold | irq}, 16'h0000);
    $display("test reset done");
    foreach (rows[i])
    begin
      i_rsv_host.wr(`RSV_A_CTRL, rows[i].ctrl);
      push(8'hb5, 1'b0, 1'b0, rows[i].crc, 1'b1, rows[i].res);
      all_sent <= rows[i].crc;
      rc(`RSV_A_STAT, {2'b10 | rows[i].crc, 2'b00, rows[i].code,
        rows[i].crc});
      i_rsv_host.wr(`RSV_A_CMD, 8'h30);
      rc(`RSV_A_STAT, {7'h00, rows[i].crc});
      rc(`RSV_A_DATA, 8'hb5 >> (3'h0 - rows[i].res));
      i_rsv_host.wr(`RSV_A_ICLR, 8'h03);
    end
    $display("test residue done");
    all_sent <= 1'b0;
    i_rsv_host.wr(`RSV_A_CTRL, 8'h62);
    i_rsv_host.wr(`RSV_A_IEN, 8'h03);
    push(8'h01, 1'b0, 1'b0, 1'b0, 1'b0, 3'd0);
    #1;
    chk({15'h0000, irq}, 16'h0001);
    rc(`RSV_A_STAT, 8'h10);
    rc(`RSV_A_IST, 8'h03);
    rc(`RSV_A_DATA, 8'h01);
    rc(`RSV_A_STAT, 8'h10);
    i_rsv_host.wr(`RSV_A_IEN, 8'h00);
    #1;
    chk({15'h0000, irq}, 16'h0000);
    i_rsv_host.wr(`RSV_A_CMD, 8'h30);
    rc(`RSV_A_STAT, 8'h00);
    i_rsv_host.wr(`RSV_A_ICLR, 8'h03);
    $display("test parity done");
    i_rsv_host.wr(`RSV_A_CTRL, 8'h60);
    i_rsv_host.wr(`RSV_A_VWR, 8'hf0);
    rc(`RSV_A_VEC_B, 8'hf0);
    i_rsv_host.wr(`RSV_A_CTRL, 8'h61);
    i_rsv_host.wr(`RSV_A_IEN, 8'h03);
    rc(`RSV_A_VEC_B, 8'hf6);
    push(8'h11, 1'b0, 1'b0, 1'b0, 1'b0, 3'd0);
    rc(`RSV_A_VEC_B, 8'hfc);
    push(8'h22, 1'b0, 1'b0, 1'b0, 1'b0, 3'd0);
    push(8'h33, 1'b0, 1'b0, 1'b0, 1'b0, 3'd0);
    push(8'h44, 1'b0, 1'b0, 1'b0, 1'b0, 3'd0);
    rc(`RSV_A_VEC_B, 8'hfe);
    rc(`RSV_A_VEC_A, 8'h00);
    rc(`RSV_A_STAT, 8'h00);
    rc(`RSV_A_DATA, 8'h11);
    rc(`RSV_A_DATA, 8'h22);
    rc(`RSV_A_STAT, 8'h20);
    rc(`RSV_A_DATA, 8'h44);
    rc(`RSV_A_STAT, 8'h20);
    i_rsv_host.wr(`RSV_A_CMD, 8'h30);
    rc(`RSV_A_STAT, 8'h00);
    i_rsv_host.wr(`RSV_A_ICLR, 8'h03);
    $display("test vector done");
    push(8'h55, 1'b0, 1'b1, 1'b0, 1'b0, 3'd0);
    #1;
    n = 16'h0000;
    while (hold === 1'b1 && n < 16'd2000)
    begin
      @(posedge clock_i);
      #1;
      n++;
    end
    chk(n, 16'(`RSV_HALF_CYC));
    push(8'h66, 1'b0, 1'b0, 1'b0, 1'b0, 3'd0);
    rc(`RSV_A_STAT, 8'h40);
    rc(`RSV_A_DATA, 8'h55);
    rc(`RSV_A_STAT, 8'h00);
    rc(`RSV_A_DATA, 8'h66);
    $display("test framing done");
    // sync mode, odd parity, then a reset in mid-run
    i_rsv_host.wr(`RSV_A_CTRL, 8'h6f);
    push(8'h77, 1'b1, 1'b0, 1'b1, 1'b0, 3'd0);
    rc(`RSV_A_STAT, 8'h40);
    @(posedge clock_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    nrst_i <= 1'b1;
    rc(`RSV_A_CTRL, 8'h60);
    rc(`RSV_A_STAT, 8'h00);
    rc(`RSV_A_DATA, 8'h00);
    chk({15'h0000, hold | irq}, 16'h0000);
    $display("test mid reset done");
    report_and_stop();
  end
endmodule : tb_top
